// *** rbt_params.svh ***
// Constants for the register block transfer sequencer
`ifndef RBT_PARAMS_SVH
`define RBT_PARAMS_SVH
`define RBT_OP_LOAD_ADDR     3'h4
`define RBT_OP_STORE_ADDR    3'h5
`define RBT_OP_LOAD_SCALAR   3'h6
`define RBT_OP_STORE_SCALAR  3'h7
`define RBT_COUNT_BITS       7
`define RBT_LOAD_RES_CP      36
`define RBT_LOAD_PORT_CP     7
`define RBT_STORE_RES_CP     4
`define RBT_STORE_PORT_CP    8
`define RBT_ZERO_RES_CP      4
`define RBT_ZERO_PORT_CP     5
`define RBT_EARLY_FREE_MAX   7'h40
`endif

// *** rbt_pkg.sv ***
// Types for the register block transfer sequencer
package rbt_pkg;
   typedef struct packed {
      logic [2:0]  op;
      logic [5:0]  firstIdx;
      logic [6:0]  count;
      logic [23:0] base;
   } rbt_cmd_t;
   typedef struct packed {
      logic        write;
      logic        portB;
      logic [23:0] addr;
      logic [63:0] data;
   } rbt_mem_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MOVE = 2'b01,
      ST_DRAIN = 2'b10
   } rbt_state_t;
endpackage : rbt_pkg

// *** rbt_fifo.sv ***
// Valid/ready FIFO held in flip-flops
`timescale 1ns/1ps
module rbt_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      fill;
   logic             doWr;
   logic             doRd;
   assign inReady  = fill != (AW+1)'(DEPTH);
   assign outValid = fill != '0;
   assign outData  = mem[rdPtr];
   assign doWr     = inValid && inReady;
   assign doRd     = outValid && outReady;
   // Pointers and fill level
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         fill  <= '0;
      end else begin
         if (doWr) wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         if (doRd) rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         fill <= fill + (AW+1)'(doWr) - (AW+1)'(doRd);
      end
   end
   // Storage
   always_ff @(posedge clk_sys) begin
      if (doWr) mem[wrPtr] <= inData;
   end
endmodule : rbt_fifo

// *** rbt_block_transfer.sv ***
// Block transfer sequencer between memory and the two save register files
// What this block does
// - Load memory words into either save file
// - Store save file words to consecutive memory
// - Register index wraps from 77 to 00
// - Word count is low seven count bits
// - Base kept; memory address steps by one
// - Address file stores zero upper 32 bits
// - Address file loads keep low 32 bits
// - Zero count moves no words
// - Count register zero means base gives length
// - Upper count bits ignored; large counts wrap
// - Address load port A, scalar load port B
// - Hold issue while base or count reserved
// - Address load hold conditions
// - Address store hold conditions
// - Scalar load hold conditions
// - Scalar store hold conditions
// - Load file reserved count plus 36
// - Load port busy count plus 7
// - Store file reserved count plus 4
// - Store port busy count plus 8
// - Enhanced short loads free registers individually
// - Issue one period; optional alignment hold
`timescale 1ns/1ps
`include "rbt_params.svh"
module rbt_block_transfer #(
   parameter bit ENHANCED = 1'b1,
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             cmdValid,
   input  wire rbt_pkg::rbt_cmd_t cmdIn,
   input  wire logic             countIsBase,
   input  wire logic             baseReserved,
   input  wire logic             countReserved,
   input  wire logic             unidirMode,
   input  wire logic             orderPending,
   input  wire logic             extBlockWrite,
   input  wire logic             sysClkPhase,
   output logic                  cmdTaken,
   output logic                  addrFileBusy,
   output logic                  scalarFileBusy,
   output logic [63:0]           regFree,
   output logic                  portABusy,
   output logic                  portBBusy,
   output logic                  memValid,
   input  wire logic             memReady,
   output rbt_pkg::rbt_mem_t     memReq,
   input  wire logic             rdValid,
   input  wire logic [63:0]      rdData,
   output logic                  rdReady,
   output logic                  fileWe,
   output logic                  fileScalar,
   output logic [5:0]            fileIdx,
   output logic [63:0]           fileWData,
   output logic                  fileRe,
   output logic [5:0]            fileRIdx,
   input  wire logic [63:0]      fileRData
);
   rbt_pkg::rbt_state_t state;
   rbt_pkg::rbt_cmd_t   cur;
   logic [6:0]  issuedLeft;
   logic [6:0]  doneLeft;
   logic [5:0]  issueIdx;
   logic [5:0]  writeIdx;
   logic [23:0] addr;
   logic [7:0]  fileTimer;
   logic [7:0]  portTimer;
   logic        portIsB;
   logic        hold;
   logic        accept;
   logic [6:0]  reqCount;
   logic        isLoad;
   logic        useB;
   logic        fifoInReady;
   logic        fifoOutValid;
   logic [63:0] fifoOutData;
   logic        fifoOutReady;

   // Opcode helpers
   function automatic logic op_is_load(input logic [2:0] op);
      op_is_load = (op == `RBT_OP_LOAD_ADDR) || (op == `RBT_OP_LOAD_SCALAR);
   endfunction : op_is_load
   function automatic logic op_is_scalar(input logic [2:0] op);
      op_is_scalar = (op == `RBT_OP_LOAD_SCALAR) || (op == `RBT_OP_STORE_SCALAR);
   endfunction : op_is_scalar

   // Length from low seven bits; base supplies it when count reg is A0
   assign reqCount = countIsBase ? cmdIn.base[`RBT_COUNT_BITS-1:0]
                                 : cmdIn.count;
   assign isLoad = op_is_load(cmdIn.op);
   // Store picks whichever port is free, A first
   assign useB = (cmdIn.op == `RBT_OP_LOAD_SCALAR) ||
                 (!isLoad && portABusy);

   // Issue holds
   always_comb begin
      hold = baseReserved || countReserved || (state != rbt_pkg::ST_IDLE);
      unique case (cmdIn.op)
         `RBT_OP_LOAD_ADDR:
            hold = hold || portABusy || unidirMode ||
                   (orderPending && extBlockWrite);
         `RBT_OP_STORE_ADDR:
            hold = hold || extBlockWrite ||
                   (unidirMode && (portABusy || portBBusy));
         `RBT_OP_LOAD_SCALAR:
            hold = hold || portBBusy || unidirMode ||
                   (orderPending && extBlockWrite);
         `RBT_OP_STORE_SCALAR:
            hold = hold || extBlockWrite || unidirMode ||
                   (orderPending && (portABusy || portBBusy));
         default: hold = 1'b1;
      endcase
      if (portABusy && portBBusy && !isLoad) hold = 1'b1;
      if (ENHANCED && !sysClkPhase) hold = 1'b1;
   end
   assign accept = cmdValid && !hold;

   // Issue acknowledge, one period
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) cmdTaken <= 1'b0;
      else cmdTaken <= accept;
   end

   // Sequencer state
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state      <= rbt_pkg::ST_IDLE;
         cur        <= '0;
         issuedLeft <= '0;
         doneLeft   <= '0;
         issueIdx   <= '0;
         writeIdx   <= '0;
         addr       <= '0;
      end else begin
         unique case (state)
            rbt_pkg::ST_IDLE: begin
               if (accept) begin
                  cur        <= cmdIn;
                  cur.count  <= reqCount;
                  issuedLeft <= reqCount;
                  doneLeft   <= reqCount;
                  issueIdx   <= cmdIn.firstIdx;
                  writeIdx   <= cmdIn.firstIdx;
                  addr       <= cmdIn.base;
                  state      <= (reqCount == '0) ? rbt_pkg::ST_IDLE
                                                 : rbt_pkg::ST_MOVE;
               end
            end
            rbt_pkg::ST_MOVE: begin
               if (memValid && memReady) begin
                  addr       <= addr + 24'h1;
                  issuedLeft <= issuedLeft - 7'h1;
                  if (!op_is_load(cur.op)) issueIdx <= issueIdx + 6'h1;
                  if (issuedLeft == 7'h1) state <= rbt_pkg::ST_DRAIN;
               end
               if (fileWe || (memValid && memReady && !op_is_load(cur.op)))
                  doneLeft <= doneLeft - 7'h1;
               if (fileWe) writeIdx <= writeIdx + 6'h1;
            end
            rbt_pkg::ST_DRAIN: begin
               if (fileWe) begin
                  doneLeft <= doneLeft - 7'h1;
                  writeIdx <= writeIdx + 6'h1;
               end
               if (doneLeft == '0 || (doneLeft == 7'h1 && fileWe) ||
                   !op_is_load(cur.op))
                  state <= rbt_pkg::ST_IDLE;
            end
            default: state <= rbt_pkg::ST_IDLE;
         endcase
      end
   end

   // Store path: one file read per word, only while no request waits,
   // so the read data is taken into the request register that same cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fileRe   <= 1'b0;
         fileRIdx <= '0;
      end else begin
         fileRe   <= (state == rbt_pkg::ST_MOVE) && !op_is_load(cur.op) && !fileRe &&
                     (!memValid || (memReady && issuedLeft != 7'h1));
         fileRIdx <= (memValid && memReady) ? issueIdx + 6'h1 : issueIdx;
      end
   end

   // Memory request register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         memValid <= 1'b0;
         memReq   <= '0;
      end else if (!memValid || memReady) begin
         memValid     <= 1'b0;
         if (state == rbt_pkg::ST_MOVE && op_is_load(cur.op) && fifoInReady &&
             !(memValid && issuedLeft == 7'h1)) begin
            memValid     <= 1'b1;
            memReq.write <= 1'b0;
            memReq.addr  <= (memValid ? addr + 24'h1 : addr);
            memReq.data  <= '0;
         end else if (fileRe) begin
            memValid     <= 1'b1;
            memReq.write <= 1'b1;
            memReq.addr  <= addr;
            memReq.data  <= op_is_scalar(cur.op) ? fileRData
                            : {32'h0, fileRData[31:0]};
         end
         memReq.portB <= portIsB;
      end
   end

   // Read data buffered before the file write
   rbt_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .inValid  (rdValid && rdReady),
      .inReady  (fifoInReady),
      .inData   (rdData),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData)
   );
   assign fifoOutReady = !fileWe;

   // Ready only when the buffer is sure to have room at the next edge
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) rdReady <= 1'b0;
      else rdReady <= fifoInReady && !(rdValid && rdReady);
   end

   // File write port
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fileWe     <= 1'b0;
         fileScalar <= 1'b0;
         fileIdx    <= '0;
         fileWData  <= '0;
      end else begin
         fileWe     <= fifoOutValid && fifoOutReady && doneLeft != '0 &&
                       op_is_load(cur.op);
         fileScalar <= op_is_scalar(cur.op);
         fileIdx    <= writeIdx;
         fileWData  <= op_is_scalar(cur.op) ? fifoOutData
                       : {32'h0, fifoOutData[31:0]};
      end
   end

   // Reservation and port busy timers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fileTimer <= '0;
         portTimer <= '0;
         portIsB   <= 1'b0;
      end else if (accept) begin
         portIsB <= useB;
         if (reqCount == '0) begin
            fileTimer <= 8'(`RBT_ZERO_RES_CP);
            portTimer <= 8'(`RBT_ZERO_PORT_CP);
         end else if (isLoad) begin
            fileTimer <= 8'(reqCount) + 8'(`RBT_LOAD_RES_CP);
            portTimer <= 8'(reqCount) + 8'(`RBT_LOAD_PORT_CP);
         end else begin
            fileTimer <= 8'(reqCount) + 8'(`RBT_STORE_RES_CP);
            portTimer <= 8'(reqCount) + 8'(`RBT_STORE_PORT_CP);
         end
      end else begin
         if (fileTimer != '0) fileTimer <= fileTimer - 8'h1;
         if (portTimer != '0) portTimer <= portTimer - 8'h1;
      end
   end

   // Busy outputs, registered
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         addrFileBusy   <= 1'b0;
         scalarFileBusy <= 1'b0;
         portABusy      <= 1'b0;
         portBBusy      <= 1'b0;
      end else begin
         addrFileBusy   <= (fileTimer > 8'h1) && !op_is_scalar(cur.op);
         scalarFileBusy <= (fileTimer > 8'h1) && op_is_scalar(cur.op);
         portABusy      <= (portTimer > 8'h1) && !portIsB;
         portBBusy      <= (portTimer > 8'h1) && portIsB;
      end
   end

   // Per-register release
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) regFree <= '1;
      else if (accept && isLoad && reqCount != '0) begin
         regFree <= '0;
      end else begin
         if (fileWe && ENHANCED && cur.count <= `RBT_EARLY_FREE_MAX)
            regFree[fileIdx] <= 1'b1;
         // Full release at the end of the reservation wins over a per-register release
         if (fileTimer == 8'h1)
            regFree <= '1;
      end
   end

   // Checks
   hold_base_a: assert property (@(posedge clk_sys) disable iff (rst)
      baseReserved |-> !accept) else $error("issue while base reserved");
   port_load_a: assert property (@(posedge clk_sys) disable iff (rst)
      accept && cmdIn.op == `RBT_OP_LOAD_ADDR |=> !portIsB)
      else $error("address load not on port A");
   store_hi_a: assert property (@(posedge clk_sys) disable iff (rst)
      memValid && memReq.write && cur.op == `RBT_OP_STORE_ADDR |-> memReq.data[63:32] == 32'h0)
      else $error("upper half not zero");
   load_hi_a: assert property (@(posedge clk_sys) disable iff (rst)
      fileWe && !fileScalar |-> fileWData[63:32] == 32'h0)
      else $error("upper half kept");
   zero_move_a: assert property (@(posedge clk_sys) disable iff (rst)
      accept && reqCount == '0 |=> state == rbt_pkg::ST_IDLE)
      else $error("zero count moved");
   load_port_a: assert property (@(posedge clk_sys) disable iff (rst)
      accept && isLoad && reqCount == 7'h1 |=> portTimer == 8'h8)
      else $error("load port time wrong");
   store_file_a: assert property (@(posedge clk_sys) disable iff (rst)
      accept && !isLoad && reqCount != '0 |=> fileTimer == 8'($past(reqCount)) + 8'h4)
      else $error("store file time wrong");
   hold_order_a: assert property (@(posedge clk_sys) disable iff (rst)
      cmdIn.op == `RBT_OP_STORE_ADDR && extBlockWrite |-> !accept)
      else $error("store issued during block write");

   // Store word: read from the file, then offered to memory
   sequence store_read_s;
      fileRe && !memValid;
   endsequence
   sequence store_offer_s;
      memValid && memReq.write;
   endsequence
   store_seq_a: assert property (@(posedge clk_sys) disable iff (rst)
      store_read_s |=> store_offer_s)
      else $error("store read not offered");
   accept_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
      accept |-> state == rbt_pkg::ST_IDLE)
      else $error("issue while busy");
   hold_count_a: assert property (@(posedge clk_sys) disable iff (rst)
      countReserved |-> !accept)
      else $error("issue while count reserved");
   hold_unidir_a: assert property (@(posedge clk_sys) disable iff (rst)
      unidirMode && isLoad |-> !accept)
      else $error("load issued in unidirectional mode");
   port_scalar_a: assert property (@(posedge clk_sys) disable iff (rst)
      accept && cmdIn.op == `RBT_OP_LOAD_SCALAR |=> portIsB)
      else $error("scalar load not on port B");
   load_file_a: assert property (@(posedge clk_sys) disable iff (rst)
      accept && isLoad && reqCount != '0 |=>
      fileTimer == 8'($past(reqCount)) + 8'(`RBT_LOAD_RES_CP))
      else $error("load file time wrong");
   store_port_a: assert property (@(posedge clk_sys) disable iff (rst)
      accept && !isLoad && reqCount != '0 |=>
      portTimer == 8'($past(reqCount)) + 8'(`RBT_STORE_PORT_CP))
      else $error("store port time wrong");
   zero_timer_a: assert property (@(posedge clk_sys) disable iff (rst)
      accept && reqCount == '0 |=> fileTimer == 8'h4 && portTimer == 8'h5)
      else $error("zero count times wrong");
   addr_step_a: assert property (@(posedge clk_sys) disable iff (rst)
      memValid && memReady && state == rbt_pkg::ST_MOVE |=> addr == $past(addr) + 24'h1)
      else $error("address did not step");
   idx_wrap_a: assert property (@(posedge clk_sys) disable iff (rst)
      fileWe && state != rbt_pkg::ST_IDLE |=> writeIdx == $past(writeIdx) + 6'h1)
      else $error("register index did not step");
   phase_a: assert property (@(posedge clk_sys) disable iff (rst)
      accept |-> !ENHANCED || sysClkPhase)
      else $error("issue off system clock phase");
endmodule : rbt_block_transfer

// *** rbt_mem_model.sv ***
// Behavioural central memory behind the block transfer sequencer
`timescale 1ns/1ps
module rbt_mem_model (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              slow,
   input  wire logic              memValid,
   output logic                   memReady,
   input  wire rbt_pkg::rbt_mem_t memReq,
   output logic                   rdValid,
   output logic [63:0]            rdData,
   input  wire logic              rdReady
);
   logic [63:0] mem [0:255];
   logic [63:0] rdQ [$];
   // Known contents so that loads can be predicted
   initial begin
      for (int i = 0; i < 256; i++)
         mem[i] = {32'(i) ^ 32'hc3a50f1e, 32'(i * 37 + 11)};
   end
   // Take writes, queue reads, stall every other cycle when slow
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         memReady <= 1'b0;
         rdValid  <= 1'b0;
         rdData   <= 64'h0;
      end else begin
         if (rdValid && rdReady)
            void'(rdQ.pop_front());
         if (memValid && memReady && memReq.write)
            mem[memReq.addr[7:0]] <= memReq.data;
         if (memValid && memReady && !memReq.write)
            rdQ.push_back(mem[memReq.addr[7:0]]);
         memReady <= !slow || !memReady;
         rdValid  <= rdQ.size() != 0;
         rdData   <= (rdQ.size() != 0) ? rdQ[0] : ~rdData; // Released bus keeps changing
      end
   end
endmodule : rbt_mem_model

// *** testbench.sv ***
// Self-checking bench for the block transfer sequencer
`timescale 1ns/1ps
`include "rbt_params.svh"
module testbench;
   logic              clk_sys, rst, cmdValid, countIsBase, baseReserved, countReserved, unidirMode;
   logic              orderPending, extBlockWrite, slow, memReady, rdValid, rdReady, fileWe, fileScalar;
   logic              fileRe, cmdTaken, addrFileBusy, scalarFileBusy, portABusy, portBBusy, memValid;
   logic              sysClkPhase = 1'b0;
   rbt_pkg::rbt_cmd_t cmdIn;
   rbt_pkg::rbt_mem_t memReq;
   logic [63:0]       regFree, rdData, fileWData, fileRData, lastRd;
   logic [5:0]        fileIdx, fileRIdx;
   logic [63:0]       aFile [64];
   logic [63:0]       sFile [64];
   logic [23:0]       curBase;
   logic [2:0]        curOp;
   int                n_errors = 0, n_tests = 0, seed = 49, nReq = 0, portCnt = 0, fileCnt = 0;

   rbt_block_transfer #(.ENHANCED(1'b1), .FIFO_DEPTH(8)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid), .cmdIn(cmdIn), .countIsBase(countIsBase),
      .baseReserved(baseReserved), .countReserved(countReserved), .unidirMode(unidirMode),
      .orderPending(orderPending), .extBlockWrite(extBlockWrite), .sysClkPhase(sysClkPhase),
      .cmdTaken(cmdTaken), .addrFileBusy(addrFileBusy), .scalarFileBusy(scalarFileBusy),
      .regFree(regFree), .portABusy(portABusy), .portBBusy(portBBusy), .memValid(memValid),
      .memReady(memReady), .memReq(memReq), .rdValid(rdValid), .rdData(rdData), .rdReady(rdReady),
      .fileWe(fileWe), .fileScalar(fileScalar), .fileIdx(fileIdx), .fileWData(fileWData),
      .fileRe(fileRe), .fileRIdx(fileRIdx), .fileRData(fileRData));
   rbt_mem_model mem_u (
      .clk_sys(clk_sys), .rst(rst), .slow(slow), .memValid(memValid), .memReady(memReady),
      .memReq(memReq), .rdValid(rdValid), .rdData(rdData), .rdReady(rdReady));

   // Clock at 20 MHz and the half-rate system clock phase
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) sysClkPhase <= ~sysClkPhase;

   // Save register files: writes on the clock, reads answer while fileRe stands
   always @(posedge clk_sys) begin
      if (fileWe && fileScalar) sFile[fileIdx] <= fileWData;
      if (fileWe && !fileScalar) aFile[fileIdx] <= fileWData;
      lastRd <= fileRData;
   end
   always_comb fileRData = fileRe ? (fileScalar ? sFile[fileRIdx] : aFile[fileRIdx]) : ~lastRd;

   // Count busy cycles and check every accepted memory request
   always @(posedge clk_sys) begin
      if (cmdTaken === 1'b1) begin
         nReq = 0;
         portCnt = 0;
         fileCnt = 0;
      end
      if ((portABusy || portBBusy) === 1'b1) portCnt++;
      if ((addrFileBusy || scalarFileBusy) === 1'b1) fileCnt++;
      if ((memValid && memReady) === 1'b1) begin
         chk("addr", 64'(memReq.addr), 64'(curBase + 24'(nReq)));
         chk("port", 64'(memReq.portB), 64'(curOp == `RBT_OP_LOAD_SCALAR));
         nReq++;
      end
   end

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   // One transfer, compared with a word-by-word model
   task automatic run(input logic [2:0] op, input logic [5:0] idx, input logic [23:0] cnt,
                      input logic [23:0] base, input logic cib, input logic slw);
      int          n, k, eF, eP;
      bit          ld, sc;
      logic [63:0] ex [64];
      n = cib ? int'(base[6:0]) : int'(cnt[6:0]);
      ld = !op[0];
      sc = op[1];
      for (k = 0; k < 64; k++) ex[k] = sc ? sFile[k] : aFile[k];
      @(negedge clk_sys);
      curOp = op;
      curBase = base;
      slow = slw;
      cmdIn = '{op: op, firstIdx: idx, count: cnt[6:0], base: base};
      countIsBase = cib;
      cmdValid = 1'b1;
      k = 0;
      while (cmdTaken !== 1'b1 && k < 100) begin @(negedge clk_sys); k++; end
      cmdValid = 1'b0;
      if (k == 100) begin n_errors++; print_verdict(); end
      k = 0;
      do begin @(negedge clk_sys); k++; end
      while ((portABusy | portBBusy | addrFileBusy | scalarFileBusy | memValid | fileRe | rdValid | fileWe)
             !== 1'b0 && k < 3000);
      if (k == 3000) begin n_errors++; print_verdict(); end
      repeat (24) @(negedge clk_sys);
      chk("words", 64'(nReq), 64'(n));
      for (k = 0; k < n; k++)
         if (ld) ex[(idx + k) % 64] = sc ? mem_u.mem[(base + k) % 256] : {32'h0, mem_u.mem[(base + k) % 256][31:0]};
      for (k = 0; k < 64 && ld; k++)
         chk("file", sc ? sFile[k] : aFile[k], ex[k]);
      for (k = 0; k < n && !ld; k++)
         chk("mem", mem_u.mem[(base + k) % 256], sc ? ex[(idx + k) % 64] : {32'h0, ex[(idx + k) % 64][31:0]});
      eF = (n == 0) ? 4 : (ld ? n + 36 : n + 4);
      eP = (n == 0) ? 5 : (ld ? n + 7 : n + 8);
      if (!slw) chk("fileBusy", 64'(fileCnt >= eF - 2 && fileCnt <= eF + 2), 64'h1);
      if (!slw) chk("portBusy", 64'(portCnt >= eP - 2 && portCnt <= eP + 2), 64'h1);
      chk("regFree", regFree, {64{1'b1}});
      $display("test op %0h count %0d done", op, n);
   endtask : run

   // Offer a command under one hold condition and expect it not to issue
   task automatic hold(input logic [2:0] op, input logic [4:0] h);
      int k, seen;
      @(negedge clk_sys);
      {baseReserved, countReserved, unidirMode, orderPending, extBlockWrite} = h;
      cmdIn = '{op: op, firstIdx: 6'h0, count: 7'h1, base: 24'h10};
      countIsBase = 1'b0;
      cmdValid = 1'b1;
      seen = 0;
      for (k = 0; k < 12; k++) begin @(negedge clk_sys); seen |= int'(cmdTaken !== 1'b0); end
      chk("held", 64'(seen), 64'h0);
      cmdValid = 1'b0;
      {baseReserved, countReserved, unidirMode, orderPending, extBlockWrite} = 5'h00;
      $display("test hold op %0h cause %0h done", op, h);
   endtask : hold

   // Reset, then every form through holds, edge counts and random runs
   initial begin
      {rst, cmdValid, countIsBase, baseReserved, countReserved, unidirMode} = 6'h20;
      {orderPending, extBlockWrite, slow} = 3'h0;
      cmdIn = '0;
      for (int k = 0; k < 64; k++) aFile[k] = {$random(seed), $random(seed)};
      for (int k = 0; k < 64; k++) sFile[k] = {$random(seed), $random(seed)};
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      for (int op = 4; op < 8; op++) begin
         hold(3'(op), 5'h10);
         hold(3'(op), 5'h08);
         hold(3'(op), 5'h03);
         hold(3'(op), op[0] ? 5'h01 : 5'h04);
         run(3'(op), 6'h3e, 24'h000005, 24'h20, 1'b0, 1'b0);
         run(3'(op), 6'h11, 24'h000000, 24'h30, 1'b0, 1'b0);
         run(3'(op), 6'h07, 24'h7fff7f, 24'h01, 1'b0, 1'b0);
         run(3'(op), 6'h2a, 24'h000033, 24'h45, 1'b1, 1'b0);
         for (int r = 0; r < 3; r++)
            run(3'(op), 6'($random(seed)), 24'($random(seed)), 24'($random(seed)) & 24'h7f, 1'($random(seed)), 1'b1);
      end
      print_verdict();
   end
endmodule : testbench
